// *** hw/gtl_top.sv ***
`timescale 1ns/1ps
// Functional notes
// - gain trim is 24-bit signed two's complement, range minus one to below one
// - output equals (gain trim plus one) times code, applied after offset trim
// - one gain trim lsb changes the multiplier by two to the minus 23
// - gain enable clear bypasses gain trim; stored value is kept
// - lock key sits in bits 23:16, reset value 0xA5
// - with key 0xA5 every register accepts writes
// - unlocked: no checksum computed, checksum field and checksum interrupt held clear
// - locked: only the lock/checksum register accepts writes
// - locked: reads of other registers return undefined data (zero here)
// - locked: checksum recomputed continuously, interrupt only when enabled
// - checksum bits 15:0 are a crc-16 over the writable registers
// - checksum field is read-only to host writes
// - checksum field updates every 12 modulator clock periods while locked
// - key equal to 0xA5 returns checksum field to 0x0000
// - offset trim adds a 24-bit signed per-channel offset to the raw code
// - gain trim registers for channel 0 and 1 sit at 0x10 and 0x12
module gtl_top
    import gtl_pkg::*;
(
    input  wire logic        clock,
    input  wire logic        sys_rst,
    input  wire logic [4:0]  reg_addr,
    input  wire logic [23:0] reg_wr_data,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [23:0] reg_rd_data,
    input  wire logic        raw_valid,
    input  wire logic [23:0] raw_code_ch0,
    input  wire logic [23:0] raw_code_ch1,
    output logic             trim_valid,
    output logic      [23:0] trim_code_ch0,
    output logic      [23:0] trim_code_ch1,
    output logic             irq
);

    // ==========================================================
    // state
    // ==========================================================
    typedef struct packed {
        logic [7:0]        lock;
        logic [15:0]       csum;
        logic              csum_valid;
        logic [1:0]        cfg;
        logic [1:0][23:0]  offset;
        logic [1:0][23:0]  gain;
        logic [1:0]        status;
        logic [1:0]        mask;
        gtl_csum_state_t   fsm;
        logic [3:0]        cnt;
        logic [143:0]      msg;
        logic [15:0]       acc;
        logic              s1_valid;
        logic [1:0][23:0]  s1_code;
        logic              out_valid;
        logic [1:0][23:0]  out_code;
        logic [23:0]       rd_data;
        logic              irq;
    } gtl_state_t;

    gtl_state_t st;
    gtl_state_t next_st;

    // ==========================================================
    // arithmetic helpers
    // ==========================================================
    // crc over one chunk of message bits, msb first
    function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [11:0] d);
        logic [15:0] r;
        logic        fb;
        r = c;
        for (int i = CRC_CHUNK - 1; i >= 0; i--) begin
            fb = r[15] ^ d[i];
            r  = {r[14:0], 1'b0};
            if (fb) begin
                r = r ^ CRC_POLY;
            end
        end
        return r;
    endfunction

    // clamp a wide signed value to the code range; top bit flags clamping
    function automatic logic [24:0] clamp26(input logic [25:0] s);
        logic [24:0] r;
        r = {1'b0, s[23:0]};
        if (s[25:23] != 3'b000 && s[25:23] != 3'b111) begin
            r = s[25] ? {1'b1, CODE_MIN} : {1'b1, CODE_MAX};
        end
        return r;
    endfunction

    // offset trim: signed add, saturating
    function automatic logic [24:0] offset_apply(input logic [23:0] code, input logic [23:0] o);
        logic signed [25:0] s;
        s = 26'($signed(code)) + 26'($signed(o));
        return clamp26(s);
    endfunction

    // gain trim: code * (g + 1.0), g in q1.23
    function automatic logic [24:0] gain_apply(input logic [23:0] code, input logic [23:0] g);
        logic signed [24:0] m;
        logic signed [48:0] p;
        m = $signed({g[23], g}) + GAIN_ONE;
        p = 49'($signed(code)) * 49'(m);
        return clamp26(p[GAIN_FRAC + 25:GAIN_FRAC]);
    endfunction

    // snapshot of the writable map, lowest address first
    function automatic logic [143:0] map_message(input gtl_state_t s);
        return {22'h000000, s.cfg, s.offset[0], s.gain[0], s.offset[1], s.gain[1],
                22'h000000, s.mask};
    endfunction

    // ==========================================================
    // next state
    // ==========================================================
    logic        locked;
    logic        csum_upd;
    logic [24:0] off_r0;
    logic [24:0] off_r1;
    logic [24:0] gain_r0;
    logic [24:0] gain_r1;
    logic [1:0]  irq_set;
    logic [1:0]  irq_clr;
    logic [15:0] acc_new;

    assign locked   = (st.lock != UNLOCK_KEY);
    assign csum_upd = (st.fsm == CS_RUN) && (st.cnt == CRC_LAST);

    // trim datapath results, computed unconditionally so both stages stay short
    assign off_r0  = offset_apply(raw_code_ch0, st.offset[0]);
    assign off_r1  = offset_apply(raw_code_ch1, st.offset[1]);
    assign gain_r0 = gain_apply(st.s1_code[0], st.gain[0]);
    assign gain_r1 = gain_apply(st.s1_code[1], st.gain[1]);
    assign acc_new = crc_step(st.acc, st.msg[MSG_W - 1 -: CRC_CHUNK]);

    always_comb begin
        next_st = st;
        irq_set = IRQ_RESET;
        irq_clr = IRQ_RESET;

        // host writes; while locked only the lock key may change
        if (reg_wr) begin
            if (reg_addr == ADDR_LOCK_CSUM) begin
                next_st.lock = reg_wr_data[LOCK_MSB:LOCK_LSB];
            end else if (!locked) begin
                case (reg_addr)
                    ADDR_CONFIG:     next_st.cfg       = reg_wr_data[CFG_W-1:0];
                    ADDR_OFFSET_CH0: next_st.offset[0] = reg_wr_data;
                    ADDR_GAIN_CH0:   next_st.gain[0]   = reg_wr_data;
                    ADDR_OFFSET_CH1: next_st.offset[1] = reg_wr_data;
                    ADDR_GAIN_CH1:   next_st.gain[1]   = reg_wr_data;
                    ADDR_IRQ_STATUS: irq_clr           = reg_wr_data[IRQ_W-1:0];
                    ADDR_IRQ_MASK:   next_st.mask      = reg_wr_data[IRQ_W-1:0];
                    default:         next_st.cfg       = st.cfg;
                endcase
            end
        end

        // read data stands in the cycle after the strobe only
        next_st.rd_data = '0;
        if (reg_rd) begin
            if (reg_addr == ADDR_LOCK_CSUM) begin
                next_st.rd_data = {st.lock, st.csum};
            end else if (!locked) begin
                case (reg_addr)
                    ADDR_CONFIG:     next_st.rd_data = 24'(st.cfg);
                    ADDR_OFFSET_CH0: next_st.rd_data = st.offset[0];
                    ADDR_GAIN_CH0:   next_st.rd_data = st.gain[0];
                    ADDR_OFFSET_CH1: next_st.rd_data = st.offset[1];
                    ADDR_GAIN_CH1:   next_st.rd_data = st.gain[1];
                    ADDR_IRQ_STATUS: next_st.rd_data = 24'(st.status);
                    ADDR_IRQ_MASK:   next_st.rd_data = 24'(st.mask);
                    default:         next_st.rd_data = '0;
                endcase
            end
        end

        // checksum sequencer: chunk per cycle, whole map per period
        case (st.fsm)
            CS_IDLE: begin
                next_st.cnt = CNT_ZERO;
                next_st.acc = CRC_INIT;
                next_st.msg = map_message(st);
                if (locked) begin
                    next_st.fsm = CS_RUN;
                end
            end
            CS_RUN: begin
                next_st.acc = acc_new;
                next_st.msg = st.msg << CRC_CHUNK;
                next_st.cnt = st.cnt + CNT_ONE;
                if (csum_upd) begin
                    // a changed checksum means the locked map was disturbed
                    next_st.csum       = acc_new;
                    next_st.csum_valid = 1'b1;
                    irq_set[IRQ_CSUM]  = st.csum_valid && (acc_new != st.csum);
                    next_st.cnt        = CNT_ZERO;
                    next_st.acc        = CRC_INIT;
                    next_st.msg        = map_message(st);
                end
                if (!locked) begin
                    next_st.fsm = CS_IDLE;
                end
            end
            default: next_st.fsm = CS_IDLE;
        endcase

        // trim pipeline: offset stage then gain stage
        next_st.s1_valid   = raw_valid;
        next_st.s1_code[0] = st.cfg[CFG_OFFSET_EN] ? off_r0[23:0] : raw_code_ch0;
        next_st.s1_code[1] = st.cfg[CFG_OFFSET_EN] ? off_r1[23:0] : raw_code_ch1;
        next_st.out_valid  = st.s1_valid;
        next_st.out_code   = st.out_code;
        if (st.s1_valid) begin
            // bypass keeps the stored gain untouched
            next_st.out_code[0] = st.cfg[CFG_GAIN_EN] ? gain_r0[23:0] : st.s1_code[0];
            next_st.out_code[1] = st.cfg[CFG_GAIN_EN] ? gain_r1[23:0] : st.s1_code[1];
        end
        irq_set[IRQ_SAT] = (raw_valid && st.cfg[CFG_OFFSET_EN] && (off_r0[24] || off_r1[24]))
                         || (st.s1_valid && st.cfg[CFG_GAIN_EN] && (gain_r0[24] || gain_r1[24]));

        // sticky status: a set in the clearing cycle wins
        next_st.status = (st.status & ~irq_clr) | irq_set;

        // unlocked map holds the checksum and its interrupt at reset value
        if (next_st.lock == UNLOCK_KEY) begin
            next_st.csum             = CSUM_RESET;
            next_st.csum_valid       = 1'b0;
            next_st.status[IRQ_CSUM] = 1'b0;
        end

        // the mask bit of the checksum event is its interrupt enable
        next_st.irq = |(next_st.status & next_st.mask);
    end

    // ==========================================================
    // state register
    // ==========================================================
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            st            <= '0;
            st.lock       <= UNLOCK_KEY;
            st.csum       <= CSUM_RESET;
            st.cfg        <= CFG_RESET;
            st.offset     <= {TRIM_RESET, TRIM_RESET};
            st.gain       <= {TRIM_RESET, TRIM_RESET};
            st.status     <= IRQ_RESET;
            st.mask       <= IRQ_RESET;
            st.fsm        <= CS_IDLE;
            st.acc        <= CRC_INIT;
        end else begin
            st <= next_st;
        end
    end

    // outputs straight from the state register
    assign reg_rd_data   = st.rd_data;
    assign trim_valid    = st.out_valid;
    assign trim_code_ch0 = st.out_code[0];
    assign trim_code_ch1 = st.out_code[1];
    assign irq           = st.irq;

    // ==========================================================
    // assertions
    // ==========================================================
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (sys_rst);

    // locked cycles since the last checksum update, saturating at one period;
    // a counter keeps the period check cheap where a long repetition would
    // be unrolled by the tools
    logic [3:0] lock_run;

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            lock_run <= CNT_ZERO;
        end else if (!locked) begin
            lock_run <= CNT_ZERO;
        end else if (csum_upd) begin
            lock_run <= CNT_ONE;
        end else if (lock_run != CNT_ZERO && lock_run != 4'(CRC_PERIOD_CYC)) begin
            lock_run <= lock_run + CNT_ONE;
        end
    end

    unlock_csum_a: assert property (st.lock == UNLOCK_KEY |-> st.csum == CSUM_RESET)
        else $error("checksum not cleared while unlocked");

    unlock_irq_a: assert property (st.lock == UNLOCK_KEY |-> !st.status[IRQ_CSUM])
        else $error("checksum interrupt set while unlocked");

    unlock_write_a: assert property (
        !locked && reg_wr && reg_addr == ADDR_GAIN_CH1 |=> st.gain[1] == $past(reg_wr_data))
        else $error("unlocked write to gain trim lost");

    locked_write_a: assert property (
        locked && reg_wr && reg_addr != ADDR_LOCK_CSUM |=> $stable(st.gain) && $stable(st.cfg)
            && $stable(st.offset) && $stable(st.mask))
        else $error("locked map accepted a write");

    locked_read_a: assert property (
        locked && reg_rd && reg_addr != ADDR_LOCK_CSUM |=> reg_rd_data == '0)
        else $error("locked read returned register contents");

    csum_ro_a: assert property (
        reg_wr && reg_addr == ADDR_LOCK_CSUM && locked && !csum_upd
            && reg_wr_data[LOCK_MSB:LOCK_LSB] != UNLOCK_KEY |=> $stable(st.csum))
        else $error("host write changed the checksum");

    csum_period_a: assert property (
        lock_run == 4'(CRC_PERIOD_CYC) |-> csum_upd)
        else $error("checksum not updated every 12 cycles");

    gain_bypass_a: assert property (
        raw_valid && !st.cfg[CFG_OFFSET_EN] && !st.cfg[CFG_GAIN_EN] ##1 !st.cfg[CFG_GAIN_EN]
            |=> trim_valid && trim_code_ch0 == $past(raw_code_ch0, 2))
        else $error("gain trim applied while disabled");

    gain_math_a: assert property (
        raw_valid && !st.cfg[CFG_OFFSET_EN] ##1 st.cfg[CFG_GAIN_EN] && $stable(st.gain)
            |=> trim_valid
            && trim_code_ch0 == 24'(gain_apply($past(raw_code_ch0, 2), $past(st.gain[0]))))
        else $error("gain trim result wrong");

    irq_mask_a: assert property (
        st.mask == IRQ_RESET ##1 st.mask == IRQ_RESET |-> !irq)
        else $error("interrupt raised while masked");

    key_write_a: assert property (
        reg_wr && reg_addr == ADDR_LOCK_CSUM |=> st.lock == $past(reg_wr_data[LOCK_MSB:LOCK_LSB]))
        else $error("lock key write lost");

    unlock_idle_a: assert property (
        !locked |=> st.fsm == CS_IDLE)
        else $error("checksum sequencer ran while unlocked");

    snap_start_a: assert property (
        locked && st.fsm == CS_IDLE |=> st.fsm == CS_RUN && st.cnt == CNT_ZERO)
        else $error("checksum pass did not start after locking");

    csum_hold_a: assert property (
        locked && !csum_upd && !reg_wr |=> $stable(st.csum))
        else $error("checksum changed between updates");

    rd_idle_a: assert property (
        !reg_rd |=> reg_rd_data == '0)
        else $error("read data shown without a read strobe");

    gain_keep_a: assert property (
        reg_wr && reg_addr == ADDR_CONFIG |=> $stable(st.gain))
        else $error("enable write disturbed stored gain trim");

    sat_sticky_a: assert property (
        st.status[IRQ_SAT] && !(reg_wr && reg_addr == ADDR_IRQ_STATUS) |=> st.status[IRQ_SAT])
        else $error("saturation status lost without a clear");

    out_hold_a: assert property (
        !st.s1_valid |=> !trim_valid && $stable(trim_code_ch0) && $stable(trim_code_ch1))
        else $error("trimmed codes changed without a sample");

    lock_cov: cover property (st.lock == UNLOCK_KEY ##1 locked ##[1:20] csum_upd);
    csum_event_cov: cover property (st.status[IRQ_CSUM] && irq);
    sat_cov: cover property (irq_set[IRQ_SAT]);
    relock_cov: cover property (csum_upd ##[1:20] st.lock == UNLOCK_KEY);
    bypass_cov: cover property (trim_valid && !st.cfg[CFG_GAIN_EN] && st.gain != '0);

endmodule

// *** inc/gtl_pkg.sv ***
// ==========================================================
// shared constants for gain trim and map lock checksum block
// ==========================================================
package gtl_pkg;

    // register bus geometry
    localparam int ADDR_W = 5;
    localparam int DATA_W = 24;

    // register addresses on the plain register port
    localparam logic [4:0] ADDR_CONFIG      = 5'h0E;
    localparam logic [4:0] ADDR_OFFSET_CH0  = 5'h0F;
    localparam logic [4:0] ADDR_GAIN_CH0    = 5'h10;
    localparam logic [4:0] ADDR_OFFSET_CH1  = 5'h11;
    localparam logic [4:0] ADDR_GAIN_CH1    = 5'h12;
    localparam logic [4:0] ADDR_IRQ_STATUS  = 5'h1C;
    localparam logic [4:0] ADDR_IRQ_MASK    = 5'h1D;
    localparam logic [4:0] ADDR_LOCK_CSUM   = 5'h1F;

    // lock and checksum register layout
    localparam int LOCK_LSB = 16;
    localparam int LOCK_MSB = 23;
    localparam logic [7:0]  UNLOCK_KEY  = 8'hA5;
    localparam logic [15:0] CSUM_RESET  = 16'h0000;

    // configuration register bits
    localparam int CFG_W          = 2;
    localparam int CFG_GAIN_EN    = 0;
    localparam int CFG_OFFSET_EN  = 1;
    localparam logic [1:0] CFG_RESET = 2'h0;

    // interrupt status and mask bits
    localparam int IRQ_W        = 2;
    localparam int IRQ_CSUM     = 0;
    localparam int IRQ_SAT      = 1;
    localparam logic [1:0] IRQ_RESET = 2'h0;

    // trim value reset and gain arithmetic
    localparam logic [23:0] TRIM_RESET  = 24'h000000;
    localparam int          GAIN_FRAC   = 23;
    localparam logic signed [24:0] GAIN_ONE = 25'sh0800000;
    localparam logic [23:0] CODE_MAX    = 24'h7FFFFF;
    localparam logic [23:0] CODE_MIN    = 24'h800000;

    // checksum engine: ccitt polynomial, all-ones start, msb first
    localparam logic [15:0] CRC_POLY    = 16'h1021;
    localparam logic [15:0] CRC_INIT    = 16'hFFFF;
    localparam int          MSG_WORDS   = 6;
    localparam int          MSG_W       = MSG_WORDS * DATA_W;
    localparam int          CRC_PERIOD_PERIODS = 12;
    localparam int          CRC_PERIOD_CYC = CRC_PERIOD_PERIODS;
    localparam int          CRC_CHUNK   = MSG_W / CRC_PERIOD_CYC;
    localparam logic [3:0]  CRC_LAST    = 4'(CRC_PERIOD_CYC - 1);
    localparam logic [3:0]  CNT_ZERO    = 4'h0;
    localparam logic [3:0]  CNT_ONE     = 4'h1;

    // checksum sequencer states, one-hot
    typedef enum logic [1:0] {
        CS_IDLE = 2'b01,
        CS_RUN  = 2'b10
    } gtl_csum_state_t;

endpackage

// *** verif/gtl_top_tb.sv ***
`timescale 1ns/1ps
module gtl_top_tb
    import gtl_pkg::*;
;
    logic        clock;
    logic        sys_rst;
    logic [4:0]  reg_addr;
    logic [23:0] reg_wr_data;
    logic        reg_wr;
    logic        reg_rd;
    logic [23:0] reg_rd_data;
    logic        raw_valid;
    logic [23:0] raw_code_ch0;
    logic [23:0] raw_code_ch1;
    logic        trim_valid;
    logic [23:0] trim_code_ch0;
    logic [23:0] trim_code_ch1;
    logic        irq;
    int          bad_count;
    int          tests_run;
    // behavioural copy of the register map
    logic [23:0] m_cfg, m_mask, m_stat;
    logic [23:0] m_off [2];
    logic [23:0] m_gain [2];
    logic [7:0]  m_key;
    logic [15:0] m_csum;
    logic [23:0] q0 [$];
    logic [23:0] q1 [$];
    logic [1:0]  vp;
    logic [4:0]  addrs [9];

    gtl_top u_gtl_top (.clock(clock), .sys_rst(sys_rst), .reg_addr(reg_addr),
        .reg_wr_data(reg_wr_data), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rd_data(reg_rd_data), .raw_valid(raw_valid), .raw_code_ch0(raw_code_ch0),
        .raw_code_ch1(raw_code_ch1), .trim_valid(trim_valid),
        .trim_code_ch0(trim_code_ch0), .trim_code_ch1(trim_code_ch1), .irq(irq));

    // ==========================================================
    // reporting
    // ==========================================================
    task automatic check(string what, logic [23:0] seen, logic [23:0] exp);
        tests_run++;
        if (seen !== exp) begin
            bad_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic report_and_stop();
        if (bad_count == 0 && tests_run > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // ==========================================================
    // reference model
    // ==========================================================
    function automatic longint sat(longint v);
        if (v > 64'sd8388607) begin
            m_stat[IRQ_SAT] = 1'b1;
            return 64'sd8388607;
        end
        if (v < -64'sd8388608) begin
            m_stat[IRQ_SAT] = 1'b1;
            return -64'sd8388608;
        end
        return v;
    endfunction

    // offset first, then gain in q23 with floor shift
    function automatic logic [23:0] trim1(logic [23:0] r, int ch);
        longint x;
        x = longint'($signed(r));
        if (m_cfg[CFG_OFFSET_EN]) x = sat(x + longint'($signed(m_off[ch])));
        if (m_cfg[CFG_GAIN_EN]) x = sat((x * (longint'($signed(m_gain[ch])) + 64'sd8388608)) >>> 23);
        return x[23:0];
    endfunction

    // ccitt, all-ones start, msb first, words in address order
    function automatic logic [15:0] crc_model();
        logic [23:0] w [6];
        logic [15:0] c;
        logic        fb;
        w = '{m_cfg, m_off[0], m_gain[0], m_off[1], m_gain[1], m_mask};
        c = CRC_INIT;
        foreach (w[i]) for (int b = 23; b >= 0; b--) begin
            fb = c[15] ^ w[i][b];
            c = {c[14:0], 1'b0};
            if (fb) c = c ^ CRC_POLY;
        end
        return c;
    endfunction

    // locked map hides every register but the lock word
    function automatic logic [23:0] m_read(logic [4:0] a);
        if (m_key != UNLOCK_KEY && a != ADDR_LOCK_CSUM) return 24'h000000;
        case (a)
            ADDR_CONFIG:     return m_cfg;
            ADDR_OFFSET_CH0: return m_off[0];
            ADDR_GAIN_CH0:   return m_gain[0];
            ADDR_OFFSET_CH1: return m_off[1];
            ADDR_GAIN_CH1:   return m_gain[1];
            ADDR_IRQ_STATUS: return m_stat;
            ADDR_IRQ_MASK:   return m_mask;
            ADDR_LOCK_CSUM:  return {m_key, m_csum};
            default:         return 24'h000000;
        endcase
    endfunction

    // ==========================================================
    // bus and sample drivers
    // ==========================================================
    task automatic wr(logic [4:0] a, logic [23:0] d);
        @(posedge clock);
        reg_addr    <= a;
        reg_wr_data <= d;
        reg_wr      <= 1'b1;
        @(posedge clock);
        reg_wr <= 1'b0;
        if (a == ADDR_LOCK_CSUM) begin
            m_key = d[23:16];
            if (m_key == UNLOCK_KEY) begin
                m_csum = 16'h0000;
                m_stat[IRQ_CSUM] = 1'b0;
            end
        end else if (m_key == UNLOCK_KEY) begin
            case (a)
                ADDR_CONFIG:     m_cfg = d & 24'h000003;
                ADDR_OFFSET_CH0: m_off[0] = d;
                ADDR_GAIN_CH0:   m_gain[0] = d;
                ADDR_OFFSET_CH1: m_off[1] = d;
                ADDR_GAIN_CH1:   m_gain[1] = d;
                ADDR_IRQ_STATUS: m_stat = m_stat & ~d;
                ADDR_IRQ_MASK:   m_mask = d & 24'h000003;
                default:         ;
            endcase
        end
    endtask

    task automatic rdc(logic [4:0] a, string what);
        logic [23:0] exp;
        exp = m_read(a);
        @(posedge clock);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge clock);
        reg_rd <= 1'b0;
        #1;
        check(what, reg_rd_data, exp);
    endtask

    // back-to-back samples, random or a fixed code on both channels
    task automatic samples(int n, bit rnd, logic [23:0] code);
        logic [23:0] a, b;
        for (int i = 0; i < n; i++) begin
            a = rnd ? 24'($urandom) : code;
            b = rnd ? 24'($urandom) : code;
            @(posedge clock);
            raw_valid    <= 1'b1;
            raw_code_ch0 <= a;
            raw_code_ch1 <= b;
            q0.push_back(trim1(a, 0));
            q1.push_back(trim1(b, 1));
        end
        @(posedge clock);
        raw_valid <= 1'b0;
        repeat (4) @(posedge clock);
    endtask

    // ==========================================================
    // output monitor: result two cycles after each sample
    // ==========================================================
    always @(negedge clock) begin
        if (sys_rst) begin
            vp <= 2'b00;
        end else begin
            check("trim_valid", {23'h0, trim_valid}, {23'h0, vp[1]});
            if (trim_valid === 1'b1 && q0.size() > 0) begin
                check("trim_code_ch0", trim_code_ch0, q0.pop_front());
                check("trim_code_ch1", trim_code_ch1, q1.pop_front());
            end
            vp <= {vp[0], raw_valid};
        end
    end

    initial begin
        clock = 1'b0;
        forever #2.5 clock = ~clock;
    end

    // hang guard, far beyond the normal run
    initial begin
        #200000;
        bad_count++;
        report_and_stop();
    end

    // ==========================================================
    // main sequence
    // ==========================================================
    initial begin
        sys_rst = 1'b1; reg_addr = 5'h00; reg_wr_data = 24'h000000; reg_wr = 1'b0;
        reg_rd = 1'b0; raw_valid = 1'b0; raw_code_ch0 = 24'h000000; raw_code_ch1 = 24'h000000;
        bad_count = 0; tests_run = 0; m_cfg = 24'h0; m_mask = 24'h0; m_stat = 24'h0;
        m_off = '{24'h0, 24'h0}; m_gain = '{24'h0, 24'h0}; m_key = UNLOCK_KEY; m_csum = 16'h0;
        addrs = '{ADDR_CONFIG, ADDR_OFFSET_CH0, ADDR_GAIN_CH0, ADDR_OFFSET_CH1, ADDR_GAIN_CH1,
                  ADDR_IRQ_STATUS, ADDR_IRQ_MASK, ADDR_LOCK_CSUM, 5'h00};
        void'($urandom(91005));
        repeat (4) @(posedge clock);
        sys_rst <= 1'b0;
        foreach (addrs[i]) rdc(addrs[i], "reset_value");
        // extreme multipliers: zero and just below two
        wr(ADDR_GAIN_CH0, 24'h800000);
        wr(ADDR_GAIN_CH1, 24'h7FFFFF);
        wr(ADDR_CONFIG, 24'h000001);
        samples(2, 1'b0, 24'h800000);
        samples(1, 1'b0, 24'h400001);
        // every enable combination with random trims
        for (int c = 0; c < 4; c++) begin
            wr(ADDR_OFFSET_CH0, 24'($urandom));
            wr(ADDR_GAIN_CH0, 24'($urandom));
            wr(ADDR_OFFSET_CH1, 24'($urandom));
            wr(ADDR_GAIN_CH1, 24'($urandom));
            wr(ADDR_CONFIG, 24'(c));
            samples(8, 1'b1, 24'h0);
            for (int i = 0; i < 5; i++) rdc(addrs[i], "trim_readback");
        end
        // saturation interrupt: raised, cleared, then masked
        wr(ADDR_CONFIG, 24'h000002);
        wr(ADDR_OFFSET_CH0, 24'h7FFFFF);
        wr(ADDR_IRQ_MASK, 24'h000002);
        wr(ADDR_IRQ_STATUS, 24'h000003);
        samples(1, 1'b0, 24'h000001);
        check("irq_raised", {23'h0, irq}, 24'h000001);
        rdc(ADDR_IRQ_STATUS, "status_set");
        wr(ADDR_IRQ_STATUS, 24'h000002);
        repeat (3) @(posedge clock);
        check("irq_cleared", {23'h0, irq}, 24'h000000);
        wr(ADDR_IRQ_MASK, 24'h000000);
        samples(1, 1'b0, 24'h000001);
        check("irq_masked", {23'h0, irq}, 24'h000000);
        rdc(ADDR_IRQ_STATUS, "status_masked");
        wr(ADDR_IRQ_STATUS, 24'h000003);
        wr(ADDR_IRQ_MASK, 24'h000001);
        // lock with a write that also tries the read-only field
        wr(ADDR_LOCK_CSUM, 24'h3CFFFF);
        rdc(ADDR_LOCK_CSUM, "csum_before_update");
        rdc(ADDR_GAIN_CH1, "locked_read");
        rdc(5'h00, "unmapped_read");
        wr(ADDR_GAIN_CH0, 24'h123456);
        wr(ADDR_IRQ_MASK, 24'h000000);
        repeat (8) @(posedge clock);
        m_csum = crc_model();
        rdc(ADDR_LOCK_CSUM, "csum_value");
        repeat (24) @(posedge clock);
        rdc(ADDR_LOCK_CSUM, "csum_steady");
        check("irq_locked", {23'h0, irq}, 24'h000000);
        samples(2, 1'b1, 24'h0);
        // unlock clears the checksum; locked writes were dropped
        wr(ADDR_LOCK_CSUM, 24'hA5FFFF);
        rdc(ADDR_LOCK_CSUM, "csum_cleared");
        rdc(ADDR_GAIN_CH0, "gain_unchanged");
        rdc(ADDR_IRQ_MASK, "mask_unchanged");
        rdc(ADDR_IRQ_STATUS, "status_after_unlock");
        report_and_stop();
    end
endmodule
